// ==== verilog/lpic_top.sv ====
/*
  Cascaded pair of eight-input interrupt controllers: request latches,
  masks, in-service bits, init/operation word decode, two-pulse acknowledge.
  Assumes single-cycle I/O write/read strobes and a one-cycle ack_i pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module lpic_top
  import lpic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  input wire logic ack_i,
  output logic [7:0] vec_o,
  output logic vec_valid_o,
  output logic cpu_irq_out_o,
  input wire logic timer0_i,
  input wire logic etimer0_i,
  input wire logic legacy_replace_select_i,
  input wire logic rtc_request_n_i,
  input wire logic [15:0] irq_lines_i,
  input wire logic [15:0] pci_routed_request_n_i,
  input wire logic [15:0] edge_level_ctrl_i
);

  // ------------------------------------------------------------
  // per-controller state
  // ------------------------------------------------------------
  logic [1:0][7:0] request_latch;
  logic [1:0][7:0] in_service_bits;
  logic [1:0][7:0] mask_bits;
  logic [1:0][7:0] prev_in;
  logic [1:0][4:0] vector_base_field;
  logic [1:0][7:0] id_word;
  logic [1:0] auto_end_of_irq;
  logic [1:0] processor_mode_bit;
  logic [1:0] special_mask_mode;
  logic [1:0] read_isr;
  logic [1:0] poll;
  lpic_init_t [1:0] init;
  logic slave_irq;

  logic [1:0][7:0] next_request_latch;
  logic [1:0][7:0] next_in_service_bits;
  logic [1:0][7:0] next_mask_bits;
  logic [1:0][7:0] next_prev_in;
  logic [1:0][4:0] next_vector_base_field;
  logic [1:0][7:0] next_id_word;
  logic [1:0] next_auto_end_of_irq;
  logic [1:0] next_processor_mode_bit;
  logic [1:0] next_special_mask_mode;
  logic [1:0] next_read_isr;
  logic [1:0] next_poll;
  lpic_init_t [1:0] next_init;
  logic next_slave_irq;
  logic next_cpu_irq;
  logic [7:0] next_rdata;
  logic next_rvalid;

  // ------------------------------------------------------------
  // acknowledge sequencer state
  // ------------------------------------------------------------
  lpic_ack_t ack_state;
  lpic_ack_t next_ack_state;
  logic [3:0] m_sel;
  logic [3:0] s_sel;
  logic [2:0] cas_id;
  logic cas_act;
  logic [3:0] next_m_sel;
  logic [3:0] next_s_sel;
  logic [2:0] next_cas_id;
  logic next_cas_act;
  logic [7:0] next_vec;
  logic next_vec_valid;

  // ------------------------------------------------------------
  // inputs and priority view
  // ------------------------------------------------------------
  logic [15:0] req;
  logic [1:0][7:0] req_c;
  logic [1:0][7:0] lvl;
  logic [1:0][7:0] elig;
  logic [1:0] sel_cmd;
  logic [1:0] sel_dat;
  logic [3:0] m_pick;
  logic [3:0] s_pick;
  logic slave_resp;
  // picks held in signals: a part-select of a call result is not legal
  logic [1:0][3:0] isr_pick;
  logic [1:0][3:0] poll_pick;

  lpic_src u_src (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .timer0_i(timer0_i),
    .etimer0_i(etimer0_i),
    .legacy_replace_select_i(legacy_replace_select_i),
    .rtc_request_n_i(rtc_request_n_i),
    .slave_irq_i(slave_irq),
    .irq_lines_i(irq_lines_i),
    .pci_routed_request_n_i(pci_routed_request_n_i),
    .req_o(req)
  );

  assign req_c = req;
  assign lvl = edge_level_ctrl_i & ~FIXED_EDGE;
  assign sel_cmd = {io_addr_i == ADDR_S_CMD, io_addr_i == ADDR_M_CMD};
  assign sel_dat = {io_addr_i == ADDR_S_DAT, io_addr_i == ADDR_M_DAT};

  // in-service bits block equal and lower levels unless special mask mode
  always_comb begin
    for (int c = 0; c < NCTL; c++) begin
      elig[c] = request_latch[c] & ~mask_bits[c] &
                ~(special_mask_mode[c] ? in_service_bits[c]
                                       : lpic_ceil(in_service_bits[c]));
    end
  end

  always_comb begin
    for (int c = 0; c < NCTL; c++) begin
      isr_pick[c] = lpic_pick(in_service_bits[c]);
      poll_pick[c] = lpic_pick(elig[c]);
    end
  end

  assign m_pick = lpic_pick(elig[MST]);
  assign s_pick = lpic_pick(elig[SLV]);
  assign slave_resp = cas_act && (cas_id == id_word[SLV][2:0]);

  // ------------------------------------------------------------
  // register file, latches and service bits
  // ------------------------------------------------------------
  always_comb begin
    next_request_latch = request_latch;
    next_in_service_bits = in_service_bits;
    next_mask_bits = mask_bits;
    next_prev_in = req_c;
    next_vector_base_field = vector_base_field;
    next_id_word = id_word;
    next_auto_end_of_irq = auto_end_of_irq;
    next_processor_mode_bit = processor_mode_bit;
    next_special_mask_mode = special_mask_mode;
    next_read_isr = read_isr;
    next_poll = poll;
    next_init = init;
    next_rdata = io_rdata_o;
    next_rvalid = 1'b0;
    next_slave_irq = |elig[SLV];
    next_cpu_irq = |elig[MST];
    // an edge latch also drops if the line falls before service
    for (int c = 0; c < NCTL; c++) begin
      next_request_latch[c] = req_c[c] &
        (lvl[c] | request_latch[c] | ~prev_in[c]);
    end
    // first pulse: winner moves into service
    if (ack_state == ACK_ONE) begin
      if (m_pick[3]) begin
        next_in_service_bits[MST] |= lpic_bit(m_pick[2:0]);
        next_request_latch[MST] &= ~lpic_bit(m_pick[2:0]);
        if (m_pick[2:0] == CASCADE_IN && s_pick[3]) begin
          next_in_service_bits[SLV] |= lpic_bit(s_pick[2:0]);
          next_request_latch[SLV] &= ~lpic_bit(s_pick[2:0]);
        end
      end
    end
    // automatic end-of-interrupt after the second pulse
    if (ack_state == ACK_TWO) begin
      if (auto_end_of_irq[MST] && m_sel[3]) begin
        next_in_service_bits[MST] &= ~lpic_bit(isr_pick[MST][2:0]);
      end
      if (auto_end_of_irq[SLV] && slave_resp && s_sel[3]) begin
        next_in_service_bits[SLV] &= ~lpic_bit(isr_pick[SLV][2:0]);
      end
    end
    for (int c = 0; c < NCTL; c++) begin
      if (io_wr_i && sel_cmd[c]) begin
        if (io_wdata_i[INIT_WORD_ONE_BIT]) begin
          next_init[c] = INIT_W2;
          next_mask_bits[c] = 8'h00;
          next_special_mask_mode[c] = 1'b0;
          next_read_isr[c] = 1'b0;
          next_poll[c] = 1'b0;
          next_id_word[c] = {5'h00, SLAVE_ID_RESET};
          next_request_latch[c] = 8'h00;
          next_prev_in[c] = 8'hFF;
        end else if (io_wdata_i[OP_WORD_READ_SELECT_BIT]) begin
          if (io_wdata_i[OP_WORD_READ_SELECT_RR]) begin
            next_read_isr[c] = io_wdata_i[OP_WORD_READ_SELECT_RIS];
          end
          if (io_wdata_i[OP_WORD_READ_SELECT_ESMM]) begin
            next_special_mask_mode[c] = io_wdata_i[OP_WORD_READ_SELECT_SMM];
          end
          next_poll[c] = io_wdata_i[OP_WORD_READ_SELECT_POLL];
        end else if (io_wdata_i[7:5] == EOI_NONSPEC) begin
          next_in_service_bits[c] &= ~lpic_bit(isr_pick[c][2:0]);
        end else if (io_wdata_i[7:5] == EOI_SPEC) begin
          next_in_service_bits[c] &= ~lpic_bit(io_wdata_i[2:0]);
        end
      end
      if (io_wr_i && sel_dat[c]) begin
        unique case (init[c])
          INIT_W2: begin
            next_vector_base_field[c] = io_wdata_i[7:VBASE_LSB];
            next_init[c] = INIT_W3;
          end
          INIT_W3: begin
            next_id_word[c] = io_wdata_i;
            next_init[c] = INIT_W4;
          end
          INIT_W4: begin
            next_auto_end_of_irq[c] = io_wdata_i[INIT_WORD_FOUR_AUTO_END_OF_IRQ];
            next_processor_mode_bit[c] = io_wdata_i[PROCESSOR_MODE_BIT];
            next_init[c] = INIT_DONE;
          end
          INIT_DONE: begin
            next_mask_bits[c] = io_wdata_i;
          end
        endcase
      end
      if (io_rd_i && sel_cmd[c]) begin
        if (poll[c]) begin
          // poll read acts as an acknowledge of this controller alone
          next_rdata = {poll_pick[c][3], 4'h0, poll_pick[c][2:0]};
          next_poll[c] = 1'b0;
          if (poll_pick[c][3]) begin
            next_in_service_bits[c] |= lpic_bit(poll_pick[c][2:0]);
            next_request_latch[c] &= ~lpic_bit(poll_pick[c][2:0]);
          end
        end else begin
          next_rdata = read_isr[c] ? in_service_bits[c] : request_latch[c];
        end
      end
      if (io_rd_i && sel_dat[c]) begin
        next_rdata = mask_bits[c];
      end
    end
    if (io_rd_i) begin
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      request_latch <= '0;
      in_service_bits <= '0;
      mask_bits <= '0;
      prev_in <= '0;
      vector_base_field <= '0;
      id_word <= {8'h07, 8'h04};
      auto_end_of_irq <= 2'h0;
      processor_mode_bit <= 2'h0;
      special_mask_mode <= 2'h0;
      read_isr <= 2'h0;
      poll <= 2'h0;
      init <= {INIT_DONE, INIT_DONE};
      slave_irq <= 1'b0;
      cpu_irq_out_o <= 1'b0;
      io_rdata_o <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      request_latch <= next_request_latch;
      in_service_bits <= next_in_service_bits;
      mask_bits <= next_mask_bits;
      prev_in <= next_prev_in;
      vector_base_field <= next_vector_base_field;
      id_word <= next_id_word;
      auto_end_of_irq <= next_auto_end_of_irq;
      processor_mode_bit <= next_processor_mode_bit;
      special_mask_mode <= next_special_mask_mode;
      read_isr <= next_read_isr;
      poll <= next_poll;
      init <= next_init;
      slave_irq <= next_slave_irq;
      cpu_irq_out_o <= next_cpu_irq;
      io_rdata_o <= next_rdata;
      io_rvalid_o <= next_rvalid;
    end
  end

  // ------------------------------------------------------------
  // two-pulse acknowledge sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_ack_state = ack_state;
    next_m_sel = m_sel;
    next_s_sel = s_sel;
    next_cas_id = cas_id;
    next_cas_act = cas_act;
    next_vec = vec_o;
    next_vec_valid = 1'b0;
    unique case (ack_state)
      ACK_IDLE: begin
        if (ack_i) begin
          next_ack_state = ACK_ONE;
        end
      end
      ACK_ONE: begin
        // freeze the winners for the rest of the cycle
        next_m_sel = m_pick;
        next_s_sel = s_pick;
        next_ack_state = ACK_CAS;
      end
      ACK_CAS: begin
        next_cas_id = m_sel[2:0];
        next_cas_act = m_sel[3] && id_word[MST][m_sel[2:0]];
        next_ack_state = ACK_TWO;
      end
      ACK_TWO: begin
        if (slave_resp) begin
          next_vec = {vector_base_field[SLV],
                      s_sel[3] ? s_sel[2:0] : SPURIOUS_IN};
        end else begin
          next_vec = {vector_base_field[MST],
                      m_sel[3] ? m_sel[2:0] : SPURIOUS_IN};
        end
        next_vec_valid = 1'b1;
        next_cas_act = 1'b0;
        next_ack_state = ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_state <= ACK_IDLE;
      m_sel <= 4'h0;
      s_sel <= 4'h0;
      cas_id <= 3'h0;
      cas_act <= 1'b0;
      vec_o <= 8'h00;
      vec_valid_o <= 1'b0;
    end else begin
      ack_state <= next_ack_state;
      m_sel <= next_m_sel;
      s_sel <= next_s_sel;
      cas_id <= next_cas_id;
      cas_act <= next_cas_act;
      vec_o <= next_vec;
      vec_valid_o <= next_vec_valid;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/lpic_pkg.sv ====
/*
  Constants, state codes and shared helper functions for the cascaded
  legacy interrupt controller pair.
  Assumes one 250 MHz clock and byte-wide I/O writes and reads.
*/
// Summary of operation
// - Master and slave eight-input controllers; slave output feeds master input 2.
// - Master input 0 is timer channel 0 or event timer 0, chosen by strap.
// - Slave input 0 is the inverted rtc request; slave input 5 is unconnected.
// - Every line is edge or level selectable except inputs 0, 2 and 8.
// - Active-low sources are inverted so high always means requesting.
// - Request latch sets on rising edge (edge mode) or high level (level mode).
// - Acknowledge sets the winner's in-service bit and clears its request latch.
// - Processor interrupt output only follows unmasked latched requests.
// - One acknowledge becomes two internal pulses; first pulse freezes the winner.
// - Vector is base bits [7:3] plus input number bits [2:0].
// - First pulse sets in-service; its trailing edge broadcasts a three-bit slave id.
// - Slave drives the vector only when the broadcast id matches its id word.
// - Vanished request makes the responding controller (master, or slave on a matched id) return its input 7 vector.
// - Auto end-of-interrupt clears in-service after pulse two, else software does.
// - Write with bit 4 set at 20h or A0h starts the four-byte init sequence.
// - Next three writes to 21h or A1h are init words two, three, four.
// - Init word one clears mask, special mask mode, selects request-latch reads.
// - Init fixes priority order, sets slave id to 7, needs fresh rising edge.
// - Operation words: mask update; end-of-interrupt; read select, special mask, poll.
// - Within a controller input 0 has highest priority, input 7 lowest.
// - Edge/level control bit 0 means rising edge, 1 means high level.
// - Non-specific end-of-interrupt clears the highest-priority set in-service bit.
package lpic_pkg;

  localparam logic [15:0] ADDR_M_CMD = 16'h0020;
  localparam logic [15:0] ADDR_M_DAT = 16'h0021;
  localparam logic [15:0] ADDR_S_CMD = 16'h00A0;
  localparam logic [15:0] ADDR_S_DAT = 16'h00A1;

  localparam int NCTL = 2;
  localparam int MST = 0;
  localparam int SLV = 1;

  localparam int IN_TIMER = 0;
  localparam int IN_CASCADE = 2;
  localparam int IN_RTC = 8;
  localparam int IN_NONE = 13;
  localparam logic [2:0] CASCADE_IN = 3'h2;
  localparam logic [2:0] SPURIOUS_IN = 3'h7;
  localparam logic [2:0] SLAVE_ID_RESET = 3'h7;
  // lines whose trigger mode is fixed to edge
  localparam logic [15:0] FIXED_EDGE = 16'h0105;

  localparam int INIT_WORD_ONE_BIT = 4;
  localparam int OP_WORD_READ_SELECT_BIT = 3;
  localparam int VBASE_LSB = 3;
  localparam int INIT_WORD_FOUR_AUTO_END_OF_IRQ = 1;
  localparam int PROCESSOR_MODE_BIT = 0;
  localparam int OP_WORD_READ_SELECT_ESMM = 6;
  localparam int OP_WORD_READ_SELECT_SMM = 5;
  localparam int OP_WORD_READ_SELECT_POLL = 2;
  localparam int OP_WORD_READ_SELECT_RR = 1;
  localparam int OP_WORD_READ_SELECT_RIS = 0;
  localparam logic [2:0] EOI_NONSPEC = 3'h1;
  localparam logic [2:0] EOI_SPEC = 3'h3;

  typedef enum logic [3:0] {
    ACK_IDLE = 4'h1,
    ACK_ONE = 4'h2,
    ACK_CAS = 4'h4,
    ACK_TWO = 4'h8
  } lpic_ack_t;

  typedef enum logic [3:0] {
    INIT_DONE = 4'h1,
    INIT_W2 = 4'h2,
    INIT_W3 = 4'h4,
    INIT_W4 = 4'h8
  } lpic_init_t;

  // {hit, index} of the highest-priority set bit, input 0 first
  function automatic logic [3:0] lpic_pick(input logic [7:0] v);
    lpic_pick = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        lpic_pick = {1'b1, 3'(i)};
      end
    end
  endfunction

  function automatic logic [7:0] lpic_bit(input logic [2:0] i);
    lpic_bit = 8'h01 << i;
  endfunction

  // every bit at or below the priority of the highest set bit
  function automatic logic [7:0] lpic_ceil(input logic [7:0] v);
    logic seen;
    seen = 1'b0;
    lpic_ceil = 8'h00;
    for (int i = 0; i < 8; i++) begin
      seen = seen | v[i];
      lpic_ceil[i] = seen;
    end
  endfunction

endpackage

// ==== verilog/lpic_src.sv ====
/*
  Request source conditioning: picks, inverts and registers the sixteen
  controller inputs.
  Assumes all sources are synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module lpic_src
  import lpic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic timer0_i,
  input wire logic etimer0_i,
  input wire logic legacy_replace_select_i,
  input wire logic rtc_request_n_i,
  input wire logic slave_irq_i,
  input wire logic [15:0] irq_lines_i,
  input wire logic [15:0] pci_routed_request_n_i,
  output logic [15:0] req_o
);

  logic [15:0] next_req;

  always_comb begin
    next_req = irq_lines_i | ~pci_routed_request_n_i;
    next_req[IN_TIMER] = legacy_replace_select_i ? etimer0_i : timer0_i;
    next_req[IN_CASCADE] = slave_irq_i;
    next_req[IN_RTC] = ~rtc_request_n_i;
    next_req[IN_NONE] = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_o <= 16'h0000;
    end else begin
      req_o <= next_req;
    end
  end

endmodule
`default_nettype wire

// ==== dv/lpic_chk.sv ====
/*
  Port checker for the interrupt controller pair.
  Assumes one clock clk_i and asynchronous reset rst_i.
*/
`timescale 1ns/1ps
`default_nettype none
module lpic_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rvalid_o,
  input wire logic ack_i,
  input wire logic [7:0] vec_o,
  input wire logic vec_valid_o,
  input wire logic cpu_irq_out_o
);
  // ----
  // acknowledge tracking
  // ----
  // ack while the sequencer runs is ignored, so only idle acks count
  logic [2:0] busy;
  logic [2:0] next_busy;
  logic take;
  assign take = ack_i && (busy == 3'h0);
  always_comb begin
    next_busy = busy;
    if (take) begin
      next_busy = 3'h3;
    end else if (busy != 3'h0) begin
      next_busy = busy - 3'h1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 3'h0;
    end else begin
      busy <= next_busy;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_rvalid_after_read:
    assert property (io_rd_i |=> io_rvalid_o) else $error("read not answered");
  a_rvalid_has_read:
    assert property (io_rvalid_o |-> $past(io_rd_i)) else $error("stray read valid");
  a_rdata_holds:
    assert property (!io_rvalid_o |-> $stable(io_rdata_o)) else $error("read data moved");
  a_ack_vec_four:
    assert property (take |-> ##4 vec_valid_o) else $error("vector late");
  a_vec_has_ack:
    assert property (vec_valid_o |-> $past(take, 4)) else $error("vector without ack");
  a_vec_one_cycle:
    assert property (vec_valid_o |=> !vec_valid_o) else $error("vector pulse long");
  a_vec_holds:
    assert property (!vec_valid_o |-> $stable(vec_o)) else $error("vector moved");
  a_quiet_after_reset:
    assert property ($past(rst_i) |-> !cpu_irq_out_o && !vec_valid_o && !io_rvalid_o)
      else $error("outputs active after reset");
  c_vector: cover property (vec_valid_o);
  c_irq: cover property ($rose(cpu_irq_out_o));
  c_read: cover property (io_rvalid_o);
endmodule
bind lpic_top lpic_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .io_rd_i(io_rd_i),
  .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .ack_i(ack_i), .vec_o(vec_o),
  .vec_valid_o(vec_valid_o), .cpu_irq_out_o(cpu_irq_out_o));
`default_nettype wire

// ==== dv/lpic_host.sv ====
/*
  Processor model: byte I/O writes and reads, acknowledge cycles.
  Assumes registered answers from the controller on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module lpic_host (
  input wire logic clk_i,
  input wire logic [7:0] io_rdata_i,
  input wire logic io_rvalid_i,
  input wire logic [7:0] vec_i,
  input wire logic vec_valid_i,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [15:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic ack_o
);
  // ----
  // bus cycles
  // ----
  initial begin
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_addr_o = 16'h0000;
    io_wdata_o = 8'h00;
    ack_o = 1'b0;
  end
  // released bus shows inverted values so stale data never matches
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_wr_o <= 1'b1;
    io_addr_o <= a;
    io_wdata_o <= d;
    @(posedge clk_i);
    io_wr_o <= 1'b0;
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    io_rd_o <= 1'b1;
    io_addr_o <= a;
    @(posedge clk_i);
    io_rd_o <= 1'b0;
    io_addr_o <= ~a;
    for (int i = 0; i < 4 && io_rvalid_i !== 1'b1; i++) @(posedge clk_i);
    d = io_rdata_i;
  endtask
  task automatic ack(output logic [7:0] v);
    @(posedge clk_i);
    ack_o <= 1'b1;
    @(posedge clk_i);
    ack_o <= 1'b0;
    for (int i = 0; i < 8 && vec_valid_i !== 1'b1; i++) @(posedge clk_i);
    v = vec_i;
  endtask
endmodule
`default_nettype wire

// ==== dv/lpic_top_test.sv ====
/*
  Self-checking bench for the controller pair, host model on the bus.
  Assumes the checker is bound in and a 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lpic_top_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic io_wr, io_rd, ack, io_rvalid, vec_valid, cpu_irq;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, vec, mb, sb, d, e;
  logic timer0 = 1'b0;
  logic etimer0 = 1'b0;
  logic lrs = 1'b0;
  logic rtc_n = 1'b1;
  logic [15:0] lines = 16'h0000;
  logic [15:0] pci_n = 16'hFFFF;
  logic [15:0] elc = 16'h0105;
  logic [3:0] n;
  integer seed = 22718;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2 clk_i = ~clk_i;
  lpic_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .io_rvalid_o(io_rvalid), .ack_i(ack), .vec_o(vec), .vec_valid_o(vec_valid),
    .cpu_irq_out_o(cpu_irq), .timer0_i(timer0), .etimer0_i(etimer0),
    .legacy_replace_select_i(lrs), .rtc_request_n_i(rtc_n), .irq_lines_i(lines),
    .pci_routed_request_n_i(pci_n), .edge_level_ctrl_i(elc));
  lpic_host host_u (.clk_i(clk_i), .io_rdata_i(io_rdata), .io_rvalid_i(io_rvalid),
    .vec_i(vec), .vec_valid_i(vec_valid), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_addr_o(io_addr), .io_wdata_o(io_wdata), .ack_o(ack));
  // ----
  // helpers
  // ----
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // callers sit in a posedge time step, so drives land off the sampling edge
  task automatic set_line(input logic [3:0] k, input logic v);
    if (k == 4'h0) begin
      if (lrs) begin
        etimer0 <= v;
      end else begin
        timer0 <= v;
      end
    end else if (k == 4'h8) begin
      rtc_n <= !v;
    end else if (!v) begin
      lines[k] <= 1'b0;
      pci_n[k] <= 1'b1;
    end else if ($random(seed) & 1) begin
      lines[k] <= 1'b1;
    end else begin
      pci_n[k] <= 1'b0;
    end
  endtask
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 24 && cpu_irq !== exp; i++) @(posedge clk_i);
    check("irq", {7'h00, cpu_irq}, {7'h00, exp});
  endtask
  task automatic init(input logic ae);
    mb = 8'($random(seed)) & 8'hF8;
    sb = 8'($random(seed)) & 8'hF8;
    host_u.wr(16'h0020, 8'h11);
    host_u.wr(16'h0021, mb);
    host_u.wr(16'h0021, 8'h04);
    host_u.wr(16'h0021, {6'h00, ae, 1'b1});
    host_u.wr(16'h00A0, 8'h11);
    host_u.wr(16'h00A1, sb);
    host_u.wr(16'h00A1, 8'h02);
    host_u.wr(16'h00A1, 8'h01);
    host_u.rd(16'h0021, d);
    check("mask", d, 8'h00);
    host_u.wr(16'h0020, 8'h0B);
  endtask
  task automatic serve(input logic [3:0] k, input logic ae, input logic lvl);
    e = {(k[3] ? sb[7:3] : mb[7:3]), k[2:0]};
    set_line(k, 1'b1);
    wait_irq(1'b1);
    host_u.ack(d);
    check("vector", d, e);
    if (!lvl) set_line(k, 1'b0);
    repeat (6) @(posedge clk_i);
    check("irq served", {7'h00, cpu_irq}, 8'h00);
    host_u.rd(16'h0020, d);
    check("in service", d, ae ? 8'h00 : 8'h01 << (k[3] ? 3'h2 : k[2:0]));
    host_u.wr(16'h0020, 8'h20);
    if (k[3]) host_u.wr(16'h00A0, 8'h20);
    host_u.rd(16'h0020, d);
    check("after eoi", d, 8'h00);
    if (lvl) begin
      wait_irq(1'b1);
      host_u.ack(d);
      check("level vector", d, e);
      set_line(k, 1'b0);
      host_u.wr(16'h0020, 8'h20);
    end
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    host_u.wr(16'h0021, 8'hFF);
    init(1'b0);
    host_u.wr(16'h0021, 8'h10);
    etimer0 <= 1'b1;
    set_line(4'h4, 1'b1);
    repeat (10) @(posedge clk_i);
    check("masked irq", {7'h00, cpu_irq}, 8'h00);
    etimer0 <= 1'b0;
    host_u.wr(16'h0021, 8'h00);
    serve(4'h4, 1'b0, 1'b0);
    set_line(4'h5, 1'b1);
    set_line(4'h3, 1'b1);
    wait_irq(1'b1);
    repeat (4) @(posedge clk_i);
    host_u.ack(d);
    check("first winner", d, {mb[7:3], 3'h3});
    set_line(4'h3, 1'b0);
    host_u.wr(16'h0020, 8'h20);
    wait_irq(1'b1);
    host_u.ack(d);
    check("second winner", d, {mb[7:3], 3'h5});
    set_line(4'h5, 1'b0);
    host_u.wr(16'h0020, 8'h20);
    set_line(4'h6, 1'b1);
    wait_irq(1'b1);
    set_line(4'h6, 1'b0);
    repeat (6) @(posedge clk_i);
    host_u.ack(d);
    check("spurious", d, {mb[7:3], 3'h7});
    host_u.wr(16'h0020, 8'h20);
    elc[5] <= 1'b1;
    @(posedge clk_i);
    serve(4'h5, 1'b0, 1'b1);
    elc[5] <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      n = 4'($random(seed));
      lrs <= 1'($random(seed));
      @(posedge clk_i);
      if (n != 4'h2 && n != 4'hD) serve(n, 1'b0, 1'b0);
    end
    set_line(4'h3, 1'b1);
    wait_irq(1'b1);
    init(1'b1);
    repeat (6) @(posedge clk_i);
    check("fresh edge", {7'h00, cpu_irq}, 8'h00);
    set_line(4'h3, 1'b0);
    serve(4'h1, 1'b1, 1'b0);
    serve(4'h9, 1'b1, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
